// [common/dtc_pkg.sv]
// constants of the dual timer/counter block
package dtc_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] RUN_FLAG_IDX = 8'h88;
  localparam logic [7:0] MODE_SEL_IDX = 8'h89;
  localparam logic [7:0] COUNT_LOW_A_IDX = 8'h8a;
  localparam logic [7:0] COUNT_LOW_B_IDX = 8'h8b;
  localparam logic [7:0] COUNT_HIGH_A_IDX = 8'h8c;
  localparam logic [7:0] COUNT_HIGH_B_IDX = 8'h8d;
  localparam logic [7:0] CLOCK_CTRL_IDX = 8'h8e;
  localparam logic [7:0] PWM_PSC_IDX = 8'h91;
  localparam logic [7:0] RELOAD_LOW_A_IDX = 8'h92;
  localparam logic [7:0] RELOAD_HIGH_A_IDX = 8'h93;
  localparam logic [7:0] RELOAD_LOW_B_IDX = 8'h94;
  localparam logic [7:0] RELOAD_HIGH_B_IDX = 8'h95;
  // reset values
  localparam logic [7:0] PWM_PSC_RST = 8'h24;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // run/flag register fields
  localparam int FLAG_B_BIT = 7;
  localparam int RUN_B_BIT = 6;
  localparam int FLAG_A_BIT = 5;
  localparam int RUN_A_BIT = 4;
  // mode select fields
  localparam int GATE_B_BIT = 7;
  localparam int SEL_B_BIT = 6;
  localparam int MODE_B_LSB = 4;
  localparam int GATE_A_BIT = 3;
  localparam int SEL_A_BIT = 2;
  localparam int MODE_A_LSB = 0;
  // pwm/prescale fields
  localparam int OE_B_BIT = 7;
  localparam int OE_A_BIT = 6;
  localparam int PSC_B_LSB = 3;
  localparam int PSC_A_LSB = 0;
  // clock control fields
  localparam int X2_A_BIT = 4;
  localparam int X2_B_BIT = 5;
  localparam int COMPAT_BIT = 6;
  // timer modes
  localparam logic [1:0] MODE_VAR = 2'h0;
  localparam logic [1:0] MODE_RLD16 = 2'h1;
  localparam logic [1:0] MODE_RLD8 = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
endpackage

// [core/dtc_core.sv]
// dual timer/counter with ahb-lite register slave
//
// Register access over AHB-Lite was left to the implementer.
module dtc_core (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // count pins, two-way
  input wire logic count_pin_a_in,
  output logic count_pin_a_out,
  output logic count_pin_a_oe,
  input wire logic count_pin_b_in,
  output logic count_pin_b_out,
  output logic count_pin_b_oe,
  // gate pins
  input wire logic gate_pin_a,
  input wire logic gate_pin_b,
  // interrupt vector acknowledges
  input wire logic int_ack_a,
  input wire logic int_ack_b,
  // overflow flags to the interrupt controller
  output logic overflow_flag_a,
  output logic overflow_flag_b
);
  typedef struct packed {
    logic [7:0] rfc;
    logic [7:0] msel;
    logic [7:0] pwmc;
    logic [7:0] ckc;
    logic [7:0] tla;
    logic [7:0] tha;
    logic [7:0] tlb;
    logic [7:0] thb;
    logic [7:0] rla;
    logic [7:0] rha;
    logic [7:0] rlb;
    logic [7:0] rhb;
    logic [3:0] div;
    logic [2:0] ca;
    logic [2:0] cb;
    logic [1:0] ga;
    logic [1:0] gb;
    logic wr;
    logic [7:0] widx;
    logic [31:0] rdata;
    logic rdy;
    logic pa;
    logic pb;
    logic oa;
    logic ob;
  } dtc_state_t;

  dtc_state_t q;
  dtc_state_t n;
  logic tick;
  logic cea;
  logic ceb;
  logic ena;
  logic enb;
  logic seta;
  logic setb;
  logic [1:0] ma;
  logic [1:0] mb;
  // active low-byte mask of timer b in mode 0
  logic [7:0] mkb;

  // one counting step: {overflow, high, low}
  function automatic logic [16:0] dtc_step(input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi,
                                           input logic [7:0] rl, input logic [7:0] rh, input logic [2:0] w);
    logic [7:0] mk;
    logic [15:0] sum;
    mk = 8'hff >> (3'h7 - w);
    sum = {hi, lo} + 16'h0001;
    dtc_step = {1'b0, hi, lo};
    case (m)
      dtc_pkg::MODE_VAR: begin
        // upper low-byte bits above the width are kept as they are
        if ((lo & mk) == mk) begin
          dtc_step = {hi == 8'hff, hi + 8'h01, lo & ~mk};
        end else begin
          dtc_step = {1'b0, hi, (lo & ~mk) | ((lo + 8'h01) & mk)};
        end
      end
      dtc_pkg::MODE_RLD16: begin
        if ({hi, lo} == 16'hffff) begin
          dtc_step = {1'b1, rh, rl};
        end else begin
          dtc_step = {1'b0, sum};
        end
      end
      dtc_pkg::MODE_RLD8: begin
        if (lo == 8'hff) begin
          dtc_step = {1'b1, hi, hi};
        end else begin
          dtc_step = {1'b0, hi, lo + 8'h01};
        end
      end
      default: begin
        dtc_step = {1'b0, hi, lo};
      end
    endcase
  endfunction

  always_comb begin
    logic [16:0] sa;
    logic [16:0] sb;
    logic [7:0] rd;
    logic hit;
    logic [7:0] wd;
    sa = 17'h00000;
    sb = 17'h00000;
    rd = 8'h00;
    wd = hwdata[7:0];
    hit = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    n = q;
    ma = q.msel[dtc_pkg::MODE_A_LSB +: 2];
    mb = q.msel[dtc_pkg::MODE_B_LSB +: 2];
    mkb = 8'hff >> (3'h7 - q.pwmc[dtc_pkg::PSC_B_LSB +: 3]);

    // shared prescale divider
    tick = (q.div == q.ckc[3:0]);
    n.div = tick ? 4'h0 : q.div + 4'h1;
    cea = (q.ckc[dtc_pkg::COMPAT_BIT] | q.ckc[dtc_pkg::X2_A_BIT]) ? tick : 1'b1;
    ceb = (q.ckc[dtc_pkg::COMPAT_BIT] | q.ckc[dtc_pkg::X2_B_BIT]) ? tick : 1'b1;

    // pin synchronisers, third stage only for falling-edge detection
    n.ca = {q.ca[1:0], count_pin_a_in};
    n.cb = {q.cb[1:0], count_pin_b_in};
    n.ga = {q.ga[0], gate_pin_a};
    n.gb = {q.gb[0], gate_pin_b};

    ena = q.rfc[dtc_pkg::RUN_A_BIT] & (~q.msel[dtc_pkg::GATE_A_BIT] | q.ga[1])
        & (q.msel[dtc_pkg::SEL_A_BIT] ? (q.ca[2] & ~q.ca[1]) : cea);
    enb = q.rfc[dtc_pkg::RUN_B_BIT] & (~q.msel[dtc_pkg::GATE_B_BIT] | q.gb[1])
        & (q.msel[dtc_pkg::SEL_B_BIT] ? (q.cb[2] & ~q.cb[1]) : ceb);

    seta = 1'b0;
    setb = 1'b0;
    if (ma == dtc_pkg::MODE_SPLIT) begin
      // low byte on timer a controls, high byte counts clocks on timer b run bit
      if (ena) begin
        {seta, n.tla} = {q.tla == 8'hff, q.tla + 8'h01};
      end
      if (q.rfc[dtc_pkg::RUN_B_BIT] & cea) begin
        {setb, n.tha} = {q.tha == 8'hff, q.tha + 8'h01};
      end
    end else if (ena) begin
      sa = dtc_step(ma, q.tla, q.tha, q.rla, q.rha, q.pwmc[dtc_pkg::PSC_A_LSB +: 3]);
      {seta, n.tha, n.tla} = sa;
    end
    if (enb) begin
      sb = dtc_step(mb, q.tlb, q.thb, q.rlb, q.rhb, q.pwmc[dtc_pkg::PSC_B_LSB +: 3]);
      {n.thb, n.tlb} = sb[15:0];
      if (ma != dtc_pkg::MODE_SPLIT) begin
        setb = sb[16];
      end
    end

    // vector acknowledge clears the flag
    n.rfc[dtc_pkg::FLAG_A_BIT] = q.rfc[dtc_pkg::FLAG_A_BIT] & ~int_ack_a;
    n.rfc[dtc_pkg::FLAG_B_BIT] = q.rfc[dtc_pkg::FLAG_B_BIT] & ~int_ack_b;

    // data phase of a write; software overrides a same-cycle count step
    if (q.wr) begin
      case (q.widx)
        dtc_pkg::RUN_FLAG_IDX: n.rfc = wd;
        dtc_pkg::MODE_SEL_IDX: n.msel = wd;
        dtc_pkg::PWM_PSC_IDX: n.pwmc = wd;
        dtc_pkg::CLOCK_CTRL_IDX: n.ckc = {1'b0, wd[6:0]};
        dtc_pkg::COUNT_LOW_A_IDX: n.tla = wd;
        dtc_pkg::COUNT_HIGH_A_IDX: n.tha = wd;
        dtc_pkg::COUNT_LOW_B_IDX: n.tlb = wd;
        dtc_pkg::COUNT_HIGH_B_IDX: n.thb = wd;
        dtc_pkg::RELOAD_LOW_A_IDX: n.rla = wd;
        dtc_pkg::RELOAD_HIGH_A_IDX: n.rha = wd;
        dtc_pkg::RELOAD_LOW_B_IDX: n.rlb = wd;
        dtc_pkg::RELOAD_HIGH_B_IDX: n.rhb = wd;
        default: n.widx = q.widx;
      endcase
    end
    // a hardware set wins over any clear in the same cycle
    n.rfc[dtc_pkg::FLAG_A_BIT] = n.rfc[dtc_pkg::FLAG_A_BIT] | seta;
    n.rfc[dtc_pkg::FLAG_B_BIT] = n.rfc[dtc_pkg::FLAG_B_BIT] | setb;

    // simple edge-aligned pulse: high while count below compare
    n.pa = q.tha < q.rha;
    n.pb = q.thb < q.rhb;
    n.oa = q.pwmc[dtc_pkg::OE_A_BIT];
    n.ob = q.pwmc[dtc_pkg::OE_B_BIT];

    // address phase; read data reflects this cycle's write
    n.wr = 1'b0;
    n.rdy = 1'b1;
    n.rdata = 32'h00000000;
    if (hsel && htrans[1] && hready && hit) begin
      n.wr = hwrite;
      n.widx = haddr[9:2];
      case (haddr[9:2])
        dtc_pkg::RUN_FLAG_IDX: rd = n.rfc;
        dtc_pkg::MODE_SEL_IDX: rd = n.msel;
        dtc_pkg::PWM_PSC_IDX: rd = n.pwmc;
        dtc_pkg::CLOCK_CTRL_IDX: rd = n.ckc;
        dtc_pkg::COUNT_LOW_A_IDX: rd = n.tla;
        dtc_pkg::COUNT_HIGH_A_IDX: rd = n.tha;
        dtc_pkg::COUNT_LOW_B_IDX: rd = n.tlb;
        dtc_pkg::COUNT_HIGH_B_IDX: rd = n.thb;
        dtc_pkg::RELOAD_LOW_A_IDX: rd = n.rla;
        dtc_pkg::RELOAD_HIGH_A_IDX: rd = n.rha;
        dtc_pkg::RELOAD_LOW_B_IDX: rd = n.rlb;
        dtc_pkg::RELOAD_HIGH_B_IDX: rd = n.rhb;
        default: rd = 8'h00;
      endcase
      if (!hwrite) begin
        n.rdata = {24'h000000, rd};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.pwmc <= dtc_pkg::PWM_PSC_RST;
      q.rfc <= dtc_pkg::ZERO_RST;
      q.msel <= dtc_pkg::ZERO_RST;
      q.rla <= dtc_pkg::RELOAD_RST;
      q.rha <= dtc_pkg::RELOAD_RST;
      q.rlb <= dtc_pkg::RELOAD_RST;
      q.rhb <= dtc_pkg::RELOAD_RST;
    end else begin
      q <= n;
    end
  end

  assign hreadyout = q.rdy;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign count_pin_a_out = q.pa;
  assign count_pin_a_oe = q.oa;
  assign count_pin_b_out = q.pb;
  assign count_pin_b_oe = q.ob;
  assign overflow_flag_a = q.rfc[dtc_pkg::FLAG_A_BIT];
  assign overflow_flag_b = q.rfc[dtc_pkg::FLAG_B_BIT];

  default clocking dcb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_stop_hold_b: assert property (
    !q.rfc[dtc_pkg::RUN_B_BIT] && !q.wr |=> $stable({q.thb, q.tlb}))
    else $error("timer b counted while stopped");
  a_split_freeze_b: assert property (
    mb == dtc_pkg::MODE_SPLIT && !q.wr |=> $stable({q.thb, q.tlb}))
    else $error("timer b moved in mode 3");
  a_reload16_b: assert property (
    mb == dtc_pkg::MODE_RLD16 && enb && {q.thb, q.tlb} == 16'hffff && !q.wr
    |=> {q.thb, q.tlb} == $past({q.rhb, q.rlb}) && (q.rfc[dtc_pkg::FLAG_B_BIT] || $past(ma) == dtc_pkg::MODE_SPLIT))
    else $error("mode 1 reload wrong");
  a_reload8_b: assert property (
    mb == dtc_pkg::MODE_RLD8 && enb && q.tlb == 8'hff && !q.wr |=> q.tlb == q.thb && $stable(q.thb))
    else $error("mode 2 reload wrong");
  a_flag_set_a: assert property (
    seta |=> q.rfc[dtc_pkg::FLAG_A_BIT] && overflow_flag_a)
    else $error("overflow flag a not set");
  a_flag_set_b: assert property (
    setb |=> overflow_flag_b)
    else $error("overflow flag b not set");
  a_ack_clear_a: assert property (
    int_ack_a && !seta && !q.wr |=> !overflow_flag_a)
    else $error("flag a not cleared by acknowledge");
  a_ack_clear_b: assert property (
    int_ack_b && !setb && !q.wr |=> !overflow_flag_b)
    else $error("flag b not cleared by acknowledge");
  a_oe_follow_b: assert property (
    q.pwmc[dtc_pkg::OE_B_BIT] ##1 q.pwmc[dtc_pkg::OE_B_BIT] |-> count_pin_b_oe)
    else $error("pin b output not enabled");
  a_oe_follow_a: assert property (
    !q.pwmc[dtc_pkg::OE_A_BIT] ##1 !q.pwmc[dtc_pkg::OE_A_BIT] |-> !count_pin_a_oe)
    else $error("pin a driven while disabled");
  a_var_carry_b: assert property (
    mb == dtc_pkg::MODE_VAR && enb && !q.wr && (q.tlb & mkb) != mkb
    |=> $stable(q.thb))
    else $error("high byte stepped without carry");
  a_var_wrap_b: assert property (
    mb == dtc_pkg::MODE_VAR && enb && ma != dtc_pkg::MODE_SPLIT && (q.tlb & mkb) == mkb && q.thb == 8'hff
    |=> overflow_flag_b && q.thb == 8'h00)
    else $error("mode 0 wrap did not flag b");
  a_rld8_flag_b: assert property (
    mb == dtc_pkg::MODE_RLD8 && enb && ma != dtc_pkg::MODE_SPLIT && q.tlb == 8'hff |=> overflow_flag_b)
    else $error("mode 2 overflow did not flag b");
  a_run_hold_a: assert property (
    !q.rfc[dtc_pkg::RUN_A_BIT] && ma != dtc_pkg::MODE_SPLIT && !q.wr |=> $stable({q.tha, q.tla}))
    else $error("timer a counted while stopped");
  a_split_high_a: assert property (
    ma == dtc_pkg::MODE_SPLIT && q.rfc[dtc_pkg::RUN_B_BIT] && cea && q.tha == 8'hff |=> overflow_flag_b)
    else $error("split high byte did not flag b");

  c_flag_a: cover property (seta);
  c_split_b: cover property (setb && ma == dtc_pkg::MODE_SPLIT);
  c_reload16: cover property (setb && mb == dtc_pkg::MODE_RLD16);
  c_var_b: cover property (setb && mb == dtc_pkg::MODE_VAR);
  c_bus_write: cover property (q.wr && q.widx == dtc_pkg::RUN_FLAG_IDX);
endmodule // dtc_core

// [tb/dtc_pin_model.sv]
// count and gate pin source standing outside the timer block
module dtc_pin_model (
  // clock
  input wire logic hclk,
  // count pin drive from the block
  input wire logic out_a,
  input wire logic oe_a,
  input wire logic out_b,
  input wire logic oe_b,
  // levels seen by the block
  output wire logic pin_a,
  output wire logic pin_b,
  output logic gate_a,
  output logic gate_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_a = 1'b1;
  logic drv_b = 1'b1;
  initial begin
    gate_a = 1'b1;
    gate_b = 1'b1;
  end
  // the block wins the pin while its enable is high
  assign pin_a = oe_a ? out_a : drv_a;
  assign pin_b = oe_b ? out_b : drv_b;
  task automatic pulse(input bit tb, input int n);
    repeat (n) begin
      repeat (4) @(posedge hclk); // each level held four cycles
      if (tb) drv_b <= 1'b0; else drv_a <= 1'b0;
      repeat (4) @(posedge hclk);
      if (tb) drv_b <= 1'b1; else drv_a <= 1'b1;
    end
    repeat (8) @(posedge hclk);
  endtask
  task automatic gate(input bit tb, input bit lvl);
    @(posedge hclk);
    if (tb) gate_b <= lvl; else gate_a <= lvl;
    repeat (4) @(posedge hclk);
  endtask
endmodule // dtc_pin_model

// [tb/dtc_core_test.sv]
// self-checking bench for the dual timer/counter
module dtc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ack_a = 1'b0;
  logic ack_b = 1'b0;
  logic hreadyout, pa_out, pa_oe, pb_out, pb_oe, pa, pb, ga, gb, fa, fb;
  logic [31:0] hrdata;
  int fail_count = 0;
  int n_tests = 0;
  dtc_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .count_pin_a_in(pa), .count_pin_a_out(pa_out), .count_pin_a_oe(pa_oe), .count_pin_b_in(pb),
    .count_pin_b_out(pb_out), .count_pin_b_oe(pb_oe), .gate_pin_a(ga), .gate_pin_b(gb), .int_ack_a(ack_a),
    .int_ack_b(ack_b), .overflow_flag_a(fa), .overflow_flag_b(fb));
  dtc_pin_model pins (.hclk(hclk), .out_a(pa_out), .oe_a(pa_oe), .out_b(pb_out), .oe_b(pb_oe), .pin_a(pa),
    .pin_b(pb), .gate_a(ga), .gate_b(gb));
  initial begin
    forever #5 hclk = ~hclk;
  end
  task automatic complete_run;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single word transfer, address phase then data phase
  // ready and read data are looked at where they stand, before the edge that samples them
  task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d, output logic [31:0] r);
    @(posedge hclk);
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin
      @(negedge hclk);
      r = hrdata;
    end while (hreadyout !== 1'b1);
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(idx, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] exp);
    logic [31:0] r;
    bus(idx, 1'b0, 8'h00, r);
    check(r & {24'h0, m}, {24'h0, exp});
  endtask
  task automatic s_reset;
    rd(dtc_pkg::PWM_PSC_IDX, 8'hff, 8'h24);
    rd(dtc_pkg::RELOAD_LOW_B_IDX, 8'hff, 8'h00);
    rd(dtc_pkg::RELOAD_HIGH_B_IDX, 8'hff, 8'h00);
    wr(8'h90, 8'hff);
    rd(8'h90, 8'hff, 8'h00);
  endtask
  task automatic s_mode1;
    wr(dtc_pkg::MODE_SEL_IDX, 8'hd0);
    wr(dtc_pkg::RELOAD_LOW_B_IDX, 8'hfc);
    wr(dtc_pkg::RELOAD_HIGH_B_IDX, 8'hff);
    wr(dtc_pkg::COUNT_LOW_B_IDX, 8'hfe);
    wr(dtc_pkg::COUNT_HIGH_B_IDX, 8'hff);
    pins.gate(1'b1, 1'b0);
    wr(dtc_pkg::RUN_FLAG_IDX, 8'h40);
    rd(dtc_pkg::COUNT_LOW_B_IDX, 8'hff, 8'hfe);
    pins.pulse(1'b1, 2);
    rd(dtc_pkg::COUNT_LOW_B_IDX, 8'hff, 8'hfe);
    pins.gate(1'b1, 1'b1);
    pins.pulse(1'b1, 3);
    rd(dtc_pkg::COUNT_LOW_B_IDX, 8'hff, 8'hfd);
    rd(dtc_pkg::COUNT_HIGH_B_IDX, 8'hff, 8'hff);
    check(fb, 32'h1);
    @(posedge hclk);
    ack_b <= 1'b1;
    @(posedge hclk);
    ack_b <= 1'b0;
    repeat (2) @(posedge hclk);
    check(fb, 32'h0);
  endtask
  task automatic s_mode23;
    wr(dtc_pkg::RUN_FLAG_IDX, 8'h00);
    wr(dtc_pkg::MODE_SEL_IDX, 8'h60);
    wr(dtc_pkg::COUNT_HIGH_B_IDX, 8'hf0);
    wr(dtc_pkg::COUNT_LOW_B_IDX, 8'hfe);
    wr(dtc_pkg::RUN_FLAG_IDX, 8'h40);
    pins.pulse(1'b1, 3);
    rd(dtc_pkg::COUNT_LOW_B_IDX, 8'hff, 8'hf1);
    rd(dtc_pkg::COUNT_HIGH_B_IDX, 8'hff, 8'hf0);
    check(fb, 32'h1);
    wr(dtc_pkg::MODE_SEL_IDX, 8'h70);
    wr(dtc_pkg::COUNT_LOW_B_IDX, 8'h12);
    pins.pulse(1'b1, 2);
    rd(dtc_pkg::COUNT_LOW_B_IDX, 8'hff, 8'h12);
  endtask
  task automatic s_mode0;
    wr(dtc_pkg::RUN_FLAG_IDX, 8'h00);
    wr(dtc_pkg::PWM_PSC_IDX, 8'h20);
    wr(dtc_pkg::MODE_SEL_IDX, 8'h44);
    wr(dtc_pkg::COUNT_LOW_A_IDX, 8'h01);
    wr(dtc_pkg::COUNT_HIGH_A_IDX, 8'hff);
    wr(dtc_pkg::COUNT_LOW_B_IDX, 8'h1f);
    wr(dtc_pkg::COUNT_HIGH_B_IDX, 8'hff);
    wr(dtc_pkg::RUN_FLAG_IDX, 8'h50);
    pins.pulse(1'b0, 1);
    pins.pulse(1'b1, 1);
    rd(dtc_pkg::COUNT_HIGH_A_IDX, 8'hff, 8'h00);
    rd(dtc_pkg::COUNT_LOW_A_IDX, 8'h01, 8'h00);
    rd(dtc_pkg::COUNT_HIGH_B_IDX, 8'hff, 8'h00);
    rd(dtc_pkg::COUNT_LOW_B_IDX, 8'h1f, 8'h00);
    check({fa, fb}, 32'h3);
  endtask
  task automatic s_oe;
    wr(dtc_pkg::PWM_PSC_IDX, 8'h80);
    repeat (2) @(posedge hclk);
    check({pb_oe, pa_oe}, 32'h2);
    wr(dtc_pkg::PWM_PSC_IDX, 8'h40);
    repeat (2) @(posedge hclk);
    check({pb_oe, pa_oe}, 32'h1);
    wr(dtc_pkg::PWM_PSC_IDX, 8'h24);
    repeat (2) @(posedge hclk);
    check({pb_oe, pa_oe}, 32'h0);
  endtask
  task automatic s_split;
    int t;
    wr(dtc_pkg::RUN_FLAG_IDX, 8'h00);
    wr(dtc_pkg::MODE_SEL_IDX, 8'h33);
    wr(dtc_pkg::COUNT_HIGH_A_IDX, 8'hfe);
    wr(dtc_pkg::COUNT_LOW_A_IDX, 8'h55);
    wr(dtc_pkg::CLOCK_CTRL_IDX, 8'h43);
    wr(dtc_pkg::RUN_FLAG_IDX, 8'h40);
    repeat (2) @(posedge hclk);
    check(fb, 32'h0);
    t = 0;
    while (fb !== 1'b1 && t++ < 40) @(posedge hclk);
    check(fb, 32'h1);
    check(fa, 32'h0);
    rd(dtc_pkg::COUNT_LOW_A_IDX, 8'hff, 8'h55);
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    s_reset();
    s_mode1();
    s_mode23();
    s_mode0();
    s_oe();
    s_split();
    complete_run();
  end
endmodule // dtc_core_test
